// ===== verilog/tci_pkg.sv
// constants, field layouts and types shared by the translation cache invalidation block
package tci_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // cached entry store geometry
   localparam int TCI_ENTRIES = 16;
   localparam int TCI_IDX_W = 4;
   localparam int TCI_PAGE_W = 52;
   localparam int TCI_PASID_W = 20;
   localparam int TCI_DID_W = 16;
   localparam int TCI_TAG_W = 91;

   // tag word layout: kind, second level flag, domain, pasid, page number
   localparam int TCI_TAG_PAGE_LSB = 0;
   localparam int TCI_TAG_PASID_LSB = 52;
   localparam int TCI_TAG_DID_LSB = 72;
   localparam int TCI_TAG_SL = 88;
   localparam int TCI_TAG_KIND_LSB = 89;

   // kinds of cached entries
   localparam logic [1:0] TCI_KIND_CTX = 2'h0;
   localparam logic [1:0] TCI_KIND_TLB = 2'h1;
   localparam logic [1:0] TCI_KIND_PSC = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // descriptor type codes and granularity codes
   localparam logic [3:0] TCI_TYPE_TLB_FLUSH = 4'h2;
   localparam logic [3:0] TCI_TYPE_CTX_FLUSH = 4'h7;
   localparam logic [1:0] TCI_G_CTX_ALL = 2'h0;
   localparam logic [1:0] TCI_G_CTX_SEL = 2'h1;
   localparam logic [1:0] TCI_G_TLB_BAD = 2'h0;
   localparam logic [1:0] TCI_G_TLB_GLOBAL = 2'h1;
   localparam logic [1:0] TCI_G_TLB_DOMAIN = 2'h2;
   localparam logic [1:0] TCI_G_TLB_PAGE = 2'h3;

   // descriptor field positions within the 128-bit word
   localparam int TCI_F_TYPE_LSB = 0;
   localparam int TCI_F_G_LSB = 4;
   localparam int TCI_F_DW = 6;
   localparam int TCI_F_DR = 7;
   localparam int TCI_F_DID_LSB = 16;
   localparam int TCI_F_PASID_LSB = 32;
   localparam int TCI_F_AM_LSB = 64;
   localparam int TCI_F_IH = 70;
   localparam int TCI_F_ADDR_LSB = 76;
   localparam logic [6:0] TCI_PAGE_SHIFT = 7'h0C;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] TCI_OFF_DESC0 = 8'h00;
   localparam logic [7:0] TCI_OFF_CMD = 8'h10;
   localparam logic [7:0] TCI_OFF_STATUS = 8'h14;
   localparam logic [7:0] TCI_OFF_CONFIG = 8'h18;
   localparam logic [7:0] TCI_OFF_WAIT = 8'h1C;
   localparam logic [7:0] TCI_OFF_ENT_TAG = 8'h20;
   localparam logic [7:0] TCI_OFF_ENT_PASID = 8'h24;
   localparam logic [7:0] TCI_OFF_ENT_PG_LO = 8'h28;
   localparam logic [7:0] TCI_OFF_ENT_PG_HI = 8'h2C;
   localparam logic [7:0] TCI_OFF_ENT_CTRL = 8'h30;
   localparam logic [7:0] TCI_OFF_VALID_MAP = 8'h34;

   // status bits
   localparam int TCI_ST_BUSY = 0;
   localparam int TCI_ST_INVALID = 1;
   localparam int TCI_ST_RD_DRAIN = 2;
   localparam int TCI_ST_WR_DRAIN = 3;
   localparam int TCI_ST_WAIT_DONE = 4;
   localparam int TCI_ST_WAIT_BUSY = 5;
   localparam int TCI_ST_FLUSH_CNT_LSB = 8;
   localparam int TCI_ST_HIT_CNT_LSB = 16;

   // config fields and reset value: flush required off, domain width 16, guest width 48
   localparam int TCI_CFG_WRITE_BUFFER_FLUSH_REQUIRED = 0;
   localparam int TCI_CFG_DIDW_LSB = 8;
   localparam int TCI_CFG_MAX_GUEST_ADDRESS_WIDTH_LSB = 16;
   localparam logic [31:0] TCI_CFG_RESET = 32'h0030_1000;
   localparam int TCI_CTRL_LOAD = 8;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int TCI_CLK_PERIOD_NS = 10;
   localparam int TCI_WBF_TIME_NS = 40;
   localparam int TCI_DRAIN_TIME_NS = 80;
   localparam logic [7:0] TCI_WBF_CYCLES = 8'((TCI_WBF_TIME_NS + TCI_CLK_PERIOD_NS - 1) / TCI_CLK_PERIOD_NS);
   localparam logic [7:0] TCI_DRAIN_CYCLES = 8'((TCI_DRAIN_TIME_NS + TCI_CLK_PERIOD_NS - 1) / TCI_CLK_PERIOD_NS);

   // sequencer states
   typedef enum logic [4:0] {
      TCI_IDLE = 5'b00001,
      TCI_FLUSH = 5'b00010,
      TCI_READ = 5'b00100,
      TCI_CHECK = 5'b01000,
      TCI_DONE = 5'b10000
   } tci_state_type;

endpackage

// ===== verilog/tci_tag_mem.sv
// tag store of the cached translation entries, registered read port
`timescale 1ns/10ps
module tci_tag_mem (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic we_in,
   input wire logic [tci_pkg::TCI_IDX_W-1:0] waddr_in,
   input wire logic [tci_pkg::TCI_TAG_W-1:0] wdata_in,
   input wire logic [tci_pkg::TCI_IDX_W-1:0] raddr_in,
   output logic [tci_pkg::TCI_TAG_W-1:0] rdata_out
);
   import tci_pkg::*;

   logic [TCI_TAG_W-1:0] mem_reg [0:TCI_ENTRIES-1];

   // array itself carries no reset; validity lives in flops outside
   always_ff @(posedge mclk_in) begin
      if (we_in) begin
         mem_reg[waddr_in] <= wdata_in;
      end
   end

   // read data is a register, available the cycle after the address
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= mem_reg[raddr_in];
      end
   end

endmodule

// ===== verilog/tci_top.sv
// translation cache invalidation engine with a classic wishbone register slave
`timescale 1ns/10ps
module tci_top (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic wb_ack_out,
   output logic [31:0] wb_dat_out,
   output logic busy_out,
   output logic wait_done_out
);
   import tci_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // byte lane merge for writable registers
   function automatic logic [31:0] apply_sel(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // command accepted only for a defined type and granularity
   function automatic logic desc_ok(input logic [127:0] d);
      logic [3:0] t;
      logic [1:0] g;
      t = d[TCI_F_TYPE_LSB +: 4];
      g = d[TCI_F_G_LSB +: 2];
      if (t == TCI_TYPE_CTX_FLUSH) begin
         return (g == TCI_G_CTX_ALL) || (g == TCI_G_CTX_SEL);
      end else if (t == TCI_TYPE_TLB_FLUSH) begin
         return g != TCI_G_TLB_BAD;
      end
      return 1'b0;
   endfunction

   // does one cached entry fall under the command; page granularity also drops first-level and context entries of the domain
   function automatic logic entry_hit(input logic [127:0] d, input logic [TCI_TAG_W-1:0] t,
                                      input logic [4:0] didw, input logic [6:0] max_guest_address_width);
      logic [15:0] dmask;
      logic [TCI_PAGE_W-1:0] pmask;
      logic [TCI_PAGE_W-1:0] rmask;
      logic did_eq;
      logic pasid_eq;
      logic in_rng;
      logic [1:0] kind;
      logic sl;
      logic [1:0] g;
      dmask = ~(16'hFFFF << didw);
      pmask = (max_guest_address_width > TCI_PAGE_SHIFT) ? ~({TCI_PAGE_W{1'b1}} << (max_guest_address_width - TCI_PAGE_SHIFT)) : '0;
      rmask = {TCI_PAGE_W{1'b1}} << d[TCI_F_AM_LSB +: 6];
      did_eq = ((t[TCI_TAG_DID_LSB +: TCI_DID_W] ^ d[TCI_F_DID_LSB +: TCI_DID_W]) & dmask) == 16'h0000;
      pasid_eq = t[TCI_TAG_PASID_LSB +: TCI_PASID_W] == d[TCI_F_PASID_LSB +: TCI_PASID_W];
      in_rng = ((t[TCI_TAG_PAGE_LSB +: TCI_PAGE_W] ^ d[TCI_F_ADDR_LSB +: TCI_PAGE_W]) & pmask & rmask) == '0;
      kind = t[TCI_TAG_KIND_LSB +: 2];
      sl = t[TCI_TAG_SL];
      g = d[TCI_F_G_LSB +: 2];
      if (d[TCI_F_TYPE_LSB +: 4] == TCI_TYPE_CTX_FLUSH) begin
         if (kind != TCI_KIND_CTX) begin
            return 1'b0;
         end
         if (g == TCI_G_CTX_ALL) begin
            return did_eq;
         end
         return did_eq && pasid_eq;
      end
      case (g)
         TCI_G_TLB_GLOBAL: begin
            return 1'b1;
         end
         TCI_G_TLB_DOMAIN: begin
            return did_eq;
         end
         TCI_G_TLB_PAGE: begin
            if (!did_eq) begin
               return 1'b0;
            end
            if (kind == TCI_KIND_TLB) begin
               return sl ? in_rng : 1'b1;
            end
            if (kind == TCI_KIND_PSC) begin
               return sl ? (in_rng && !d[TCI_F_IH]) : 1'b1;
            end
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic wb_req;
   logic wb_wr;
   logic [7:0] wb_word;
   logic [31:0] desc_reg [0:3];
   logic [127:0] desc_all;
   logic [127:0] cmd_reg;
   logic [31:0] cfg_reg;
   logic [31:0] ent_tag_reg;
   logic [31:0] ent_pasid_reg;
   logic [31:0] ent_pg_lo_reg;
   logic [31:0] ent_pg_hi_reg;
   logic [TCI_ENTRIES-1:0] valid_reg;
   tci_state_type state_reg;
   logic [TCI_IDX_W-1:0] idx_reg;
   logic [7:0] timer_reg;
   logic [7:0] flush_cnt_reg;
   logic [7:0] hit_cnt_reg;
   logic invalid_reg;
   logic rd_drain_reg;
   logic wr_drain_reg;
   logic wait_busy_reg;
   logic [7:0] drain_timer_reg;
   logic [TCI_TAG_W-1:0] tag_rd;
   logic go_write;
   logic go_accept;
   logic wait_write;
   logic status_write;
   logic load_write;
   logic hit_now;
   logic drain_end;
   logic wait_finish;

   assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wb_wr = wb_req && wb_we_in;
   assign wb_word = {wb_adr_in[7:2], 2'b00};
   assign desc_all = {desc_reg[3], desc_reg[2], desc_reg[1], desc_reg[0]};
   assign go_write = wb_wr && wb_word == TCI_OFF_CMD && wb_sel_in[0] && wb_dat_in[0];
   assign go_accept = go_write && state_reg == TCI_IDLE; // a go while busy is dropped
   assign wait_write = wb_wr && wb_word == TCI_OFF_WAIT && wb_sel_in[0] && wb_dat_in[0];
   assign status_write = wb_wr && wb_word == TCI_OFF_STATUS && wb_sel_in[0];
   assign load_write = wb_wr && wb_word == TCI_OFF_ENT_CTRL && wb_sel_in[1] && wb_dat_in[TCI_CTRL_LOAD];
   assign hit_now = state_reg == TCI_CHECK && valid_reg[idx_reg] &&
                    entry_hit(cmd_reg, tag_rd, cfg_reg[TCI_CFG_DIDW_LSB +: 5], cfg_reg[TCI_CFG_MAX_GUEST_ADDRESS_WIDTH_LSB +: 7]);
   assign drain_end = drain_timer_reg == 8'h01;
   assign wait_finish = wait_busy_reg && state_reg == TCI_IDLE && !rd_drain_reg && !wr_drain_reg &&
                        drain_timer_reg == 8'h00;

   // one-cycle ack; it drops the cycle after so back to back requests see a gap
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= wb_req;
      end
   end

   // descriptor words are frozen while a command runs
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_desc
         always_ff @(posedge mclk_in) begin
            if (srst_in) begin
               desc_reg[gi] <= 32'h0000_0000;
            end else if (wb_wr && wb_word == TCI_OFF_DESC0 + 8'(4 * gi) && state_reg == TCI_IDLE) begin
               desc_reg[gi] <= apply_sel(desc_reg[gi], wb_dat_in, wb_sel_in);
            end
         end
      end
   endgenerate

   // configuration and entry staging registers
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         cfg_reg <= TCI_CFG_RESET;
         ent_tag_reg <= 32'h0000_0000;
         ent_pasid_reg <= 32'h0000_0000;
         ent_pg_lo_reg <= 32'h0000_0000;
         ent_pg_hi_reg <= 32'h0000_0000;
      end else if (wb_wr) begin
         if (wb_word == TCI_OFF_CONFIG) begin
            cfg_reg <= apply_sel(cfg_reg, wb_dat_in, wb_sel_in);
         end
         if (wb_word == TCI_OFF_ENT_TAG) begin
            ent_tag_reg <= apply_sel(ent_tag_reg, wb_dat_in, wb_sel_in);
         end
         if (wb_word == TCI_OFF_ENT_PASID) begin
            ent_pasid_reg <= apply_sel(ent_pasid_reg, wb_dat_in, wb_sel_in);
         end
         if (wb_word == TCI_OFF_ENT_PG_LO) begin
            ent_pg_lo_reg <= apply_sel(ent_pg_lo_reg, wb_dat_in, wb_sel_in);
         end
         if (wb_word == TCI_OFF_ENT_PG_HI) begin
            ent_pg_hi_reg <= apply_sel(ent_pg_hi_reg, wb_dat_in, wb_sel_in);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // entry store

   tci_tag_mem u_tag_mem (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .we_in(load_write),
      .waddr_in(wb_dat_in[TCI_IDX_W-1:0]),
      .wdata_in({ent_tag_reg[17:16], ent_tag_reg[18], ent_tag_reg[15:0], ent_pasid_reg[TCI_PASID_W-1:0],
                 ent_pg_hi_reg[19:0], ent_pg_lo_reg}),
      .raddr_in(idx_reg),
      .rdata_out(tag_rd)
   );

   // valid bits: a load in the same cycle as a walk clear wins
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         valid_reg <= '0;
      end else begin
         valid_reg <= (valid_reg & ~(TCI_ENTRIES'(hit_now) << idx_reg)) |
                      (TCI_ENTRIES'(load_write) << wb_dat_in[TCI_IDX_W-1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer

   // latch the command so later descriptor edits cannot disturb the walk
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         cmd_reg <= '0;
      end else if (go_accept) begin
         cmd_reg <= desc_all;
      end
   end

   // idle, optional write buffer flush, then two cycles per entry across the store
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_reg <= TCI_IDLE;
      end else begin
         case (state_reg)
            TCI_IDLE: begin
               if (go_accept && desc_ok(desc_all)) begin
                  state_reg <= cfg_reg[TCI_CFG_WRITE_BUFFER_FLUSH_REQUIRED] ? TCI_FLUSH : TCI_READ;
               end
            end
            TCI_FLUSH: begin
               if (timer_reg == 8'h01) begin
                  state_reg <= TCI_READ;
               end
            end
            TCI_READ: begin
               state_reg <= TCI_CHECK;
            end
            TCI_CHECK: begin
               state_reg <= (idx_reg == TCI_IDX_W'(TCI_ENTRIES - 1)) ? TCI_DONE : TCI_READ;
            end
            TCI_DONE: begin
               state_reg <= TCI_IDLE;
            end
            default: begin
               state_reg <= TCI_IDLE;
            end
         endcase
      end
   end

   // walk index and flush timer
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         idx_reg <= '0;
         timer_reg <= 8'h00;
      end else begin
         if (go_accept) begin
            idx_reg <= '0;
            timer_reg <= TCI_WBF_CYCLES;
         end else if (state_reg == TCI_CHECK) begin
            idx_reg <= idx_reg + 1'b1;
         end
         if (state_reg == TCI_FLUSH) begin
            timer_reg <= timer_reg - 8'h01;
         end
      end
   end

   // counters software can watch: write buffer flushes and entries dropped by the last command
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         flush_cnt_reg <= 8'h00;
         hit_cnt_reg <= 8'h00;
      end else begin
         if (state_reg == TCI_FLUSH && timer_reg == 8'h01) begin
            flush_cnt_reg <= flush_cnt_reg + 8'h01;
         end
         if (go_accept) begin
            hit_cnt_reg <= 8'h00;
         end else if (hit_now) begin
            hit_cnt_reg <= hit_cnt_reg + 8'h01;
         end
      end
   end

   // invalid command flag, write one to clear, a new fault wins over the clear
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         invalid_reg <= 1'b0;
      end else if (go_accept && !desc_ok(desc_all)) begin
         invalid_reg <= 1'b1;
      end else if (status_write && wb_dat_in[TCI_ST_INVALID]) begin
         invalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // drain and wait

   // drain requests collect at the end of a TLB flush walk until a wait drains them
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         rd_drain_reg <= 1'b0;
         wr_drain_reg <= 1'b0;
      end else begin
         if (state_reg == TCI_DONE && cmd_reg[TCI_F_TYPE_LSB +: 4] == TCI_TYPE_TLB_FLUSH && cmd_reg[TCI_F_DR]) begin
            rd_drain_reg <= 1'b1;
         end else if (drain_end) begin
            rd_drain_reg <= 1'b0;
         end
         if (state_reg == TCI_DONE && cmd_reg[TCI_F_TYPE_LSB +: 4] == TCI_TYPE_TLB_FLUSH && cmd_reg[TCI_F_DW]) begin
            wr_drain_reg <= 1'b1;
         end else if (drain_end) begin
            wr_drain_reg <= 1'b0;
         end
      end
   end

   // a wait holds until the engine is idle and every pending drain has run its time
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         wait_busy_reg <= 1'b0;
         drain_timer_reg <= 8'h00;
      end else begin
         if (wait_write) begin
            wait_busy_reg <= 1'b1;
         end else if (wait_finish) begin
            wait_busy_reg <= 1'b0;
         end
         if (drain_timer_reg != 8'h00) begin
            drain_timer_reg <= drain_timer_reg - 8'h01;
         end else if (wait_busy_reg && state_reg == TCI_IDLE && (rd_drain_reg || wr_drain_reg)) begin
            drain_timer_reg <= TCI_DRAIN_CYCLES;
         end
      end
   end

   // completion flag and busy pins; completion wins over a clear in the same cycle
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         wait_done_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         if (wait_finish) begin
            wait_done_out <= 1'b1;
         end else if (status_write && wb_dat_in[TCI_ST_WAIT_DONE]) begin
            wait_done_out <= 1'b0;
         end
         busy_out <= (state_reg != TCI_IDLE && state_reg != TCI_DONE) || (go_accept && desc_ok(desc_all));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, registered alongside ack; unmapped words read zero

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (wb_req && !wb_we_in) begin
         case (wb_word)
            TCI_OFF_DESC0: wb_dat_out <= desc_reg[0];
            TCI_OFF_DESC0 + 8'h04: wb_dat_out <= desc_reg[1];
            TCI_OFF_DESC0 + 8'h08: wb_dat_out <= desc_reg[2];
            TCI_OFF_DESC0 + 8'h0C: wb_dat_out <= desc_reg[3];
            TCI_OFF_STATUS: begin
               wb_dat_out <= {8'h00, hit_cnt_reg, flush_cnt_reg, 2'b00, wait_busy_reg, wait_done_out,
                              wr_drain_reg, rd_drain_reg, invalid_reg, busy_out};
            end
            TCI_OFF_CONFIG: wb_dat_out <= cfg_reg;
            TCI_OFF_ENT_TAG: wb_dat_out <= ent_tag_reg;
            TCI_OFF_ENT_PASID: wb_dat_out <= ent_pasid_reg;
            TCI_OFF_ENT_PG_LO: wb_dat_out <= ent_pg_lo_reg;
            TCI_OFF_ENT_PG_HI: wb_dat_out <= ent_pg_hi_reg;
            TCI_OFF_VALID_MAP: wb_dat_out <= {16'h0000, valid_reg};
            default: wb_dat_out <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// ===== verif/tci_sva.sv
// concurrent checks on the bus and status ports of the invalidation engine
`timescale 1ns/10ps
module tci_sva (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic wb_ack_out,
   input wire logic [31:0] wb_dat_out,
   input wire logic busy_out,
   input wire logic wait_done_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (srst_in);
   logic req;
   logic wr0;
   // a held strobe during ack is not a new request
   assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr0 = req && wb_we_in && wb_sel_in[0];
   a_ack_one_pulse: assert property (req |=> wb_ack_out ##1 !wb_ack_out)
      else $error("ack not one pulse");
   a_ack_has_cause: assert property ($rose(wb_ack_out) |-> $past(req))
      else $error("ack without request");
   a_rdata_at_ack: assert property ($changed(wb_dat_out) |-> wb_ack_out)
      else $error("read data moved");
   a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 8'h37 |-> wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
   a_busy_needs_go: assert property ($rose(busy_out) |-> $past(wr0 && wb_adr_in[7:2] == 6'h04))
      else $error("walk without start");
   a_busy_span: assert property ($rose(busy_out) |-> busy_out[*8] ##[26:30] !busy_out)
      else $error("walk length wrong");
   a_wait_bounded: assert property (wr0 && wb_adr_in[7:2] == 6'h07 && wb_dat_in[0] && !busy_out
      |-> ##[2:12] wait_done_out) else $error("wait late");
   a_wait_sticky: assert property (wait_done_out && !(wr0 && wb_adr_in[7:2] == 6'h05 && wb_dat_in[4])
      |=> wait_done_out) else $error("wait flag lost");
   c_walk_done: cover property ($fell(busy_out));
   c_wait_done: cover property ($rose(wait_done_out));
   c_map_read: cover property (wb_ack_out && wb_adr_in == 8'h34);
endmodule

bind tci_top tci_sva u_sva (.mclk_in(mclk_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
   .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .busy_out(busy_out),
   .wait_done_out(wait_done_out));

// ===== verif/tci_sw_model.sv
// software side: writes a caller-built descriptor word by word and drives the register bus
`timescale 1ns/10ps
module tci_sw_model (
   input wire logic mclk_in,
   input wire logic ack_in,
   input wire logic [31:0] dat_in,
   output logic cyc_out,
   output logic stb_out,
   output logic we_out,
   output logic [7:0] adr_out,
   output logic [3:0] sel_out,
   output logic [31:0] dat_out
);
   // bus idle from time zero
   initial {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
   // one classic cycle; released address and data lines show inverted values so stale data never matches
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk_in);
      cyc_out <= 1;
      stb_out <= 1;
      we_out <= w;
      adr_out <= a;
      sel_out <= 4'hF;
      dat_out <= d;
      do @(posedge mclk_in); while (ack_in !== 1'b1);
      q = dat_in;
      cyc_out <= 0;
      stb_out <= 0;
      adr_out <= ~a;
      dat_out <= ~d;
   endtask
   // low word first, start written last
   task automatic post(input logic [127:0] c);
      logic [31:0] q;
      for (int k = 0; k < 4; k++) xfer(1, 8'(4 * k), c[32 * k +: 32], q);
      xfer(1, 8'h10, 32'h1, q);
   endtask
endmodule

// ===== verif/tb.sv
// bench: random entries, every command code, drains, waits, flush counting
`timescale 1ns/10ps
module tb;
   import tci_pkg::*;
   logic mclk_in = 0, srst_in = 1, cyc, stb, we, ack, busy, wdone, ok;
   logic [7:0] adr, fc;
   logic [3:0] sel;
   logic [31:0] wd, rd, q;
   logic [15:0] dm [16];
   logic [19:0] ps [16];
   logic [31:0] pg [16];
   logic [1:0] kd [16];
   logic [15:0] sl, vm;
   logic [127:0] c;
   logic [4:0] n;
   int seed = 28402, err_count = 0, checked = 0, cyc_cnt = 0, i, r, j;
   // {granularity, type}; context flush codes are each followed by a TLB flush code
   logic [5:0] tbl [8] = '{6'h07, 6'h12, 6'h17, 6'h22, 6'h32, 6'h27, 6'h02, 6'h15};
   tci_top u_dut (.mclk_in(mclk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_ack_out(ack),
      .wb_dat_out(rd), .busy_out(busy), .wait_done_out(wdone));
   tci_sw_model u_sw (.mclk_in(mclk_in), .ack_in(ack), .dat_in(rd), .cyc_out(cyc),
      .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wd));
   initial forever #5 mclk_in = ~mclk_in;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checked %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // entry i dropped by command c; domain on low n bits, page from bit mask upward
   function automatic logic hit(int i);
      logic d, a;
      d = ((dm[i] ^ c[31:16]) & 16'((32'h1 << n) - 1)) == 0;
      a = ((pg[i] ^ c[107:76]) >> c[69:64]) == 0;
      if (c[3:0] == 4'h7) return kd[i] == 0 && d && (!c[4] || ps[i] == c[51:32]);
      if (c[5:4] == 2'h1) return 1'b1;
      return d && (c[5:4] == 2'h2 || kd[i] == 0 || !sl[i] || a && (kd[i] == 1 || !c[70]));
   endfunction
   // hang guard
   always @(posedge mclk_in) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 30000) begin
         err_count++;
         print_verdict;
      end
   end
   initial begin
      fc = 0;
      repeat (16) @(posedge mclk_in);
      srst_in <= 0;
      u_sw.xfer(0, TCI_OFF_CONFIG, 0, q);
      chk(q, 32'h0030_1000);
      u_sw.xfer(0, 8'h3C, 0, q);
      chk(q, 0);
      for (r = 0; r < 16; r++) begin
         n = r[2] ? 5'h08 : 5'h10;
         u_sw.xfer(1, TCI_OFF_CONFIG, {16'h0030, 3'h0, n, 7'h0, r[0]}, q);
         for (i = 0; i < 16; i++) begin
            dm[i] = 16'($random(seed)) & 16'h0101;
            ps[i] = 20'($random(seed)) & 20'h3;
            pg[i] = 32'($random(seed)) & 32'h3FFFF;
            kd[i] = 2'({$random(seed)} % 3);
            sl[i] = 1'($random(seed));
            u_sw.xfer(1, TCI_OFF_ENT_TAG, {13'h0, sl[i], kd[i], dm[i]}, q);
            u_sw.xfer(1, TCI_OFF_ENT_PASID, {12'h0, ps[i]}, q);
            u_sw.xfer(1, TCI_OFF_ENT_PG_LO, pg[i], q);
            u_sw.xfer(1, TCI_OFF_ENT_PG_HI, 0, q);
            u_sw.xfer(1, TCI_OFF_ENT_CTRL, 32'h100 | i, q);
         end
         j = {$random(seed)} % 16;
         c = {16'($random(seed)), 4'h0, pg[j], 5'h0, r[3], 6'((r % 3) * 9), 12'h0, ps[j], dm[j], 16'h0};
         c[31:16] = c[31:16] ^ (16'($random(seed)) & ~16'((32'h1 << n) - 1));
         c[7:0] = {2'($random(seed)), tbl[r % 8]};
         ok = (c[3:0] == 4'h7 && !c[5]) || (c[3:0] == 4'h2 && c[5:4] != 0);
         for (i = 0; i < 16; i++) vm[i] = !(ok && hit(i));
         fc = fc + 8'(ok && r[0]);
         u_sw.post(c);
         for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge mclk_in);
         chk(busy, 0);
         u_sw.xfer(0, TCI_OFF_STATUS, 0, q);
         chk(q[15:8], fc);
         chk(q[3:1], {c[3:0] == 4'h2 && ok ? {c[6], c[7]} : 2'h0, !ok});
         if (ok) chk(q[23:16], 32'(16 - $countones(vm)));
         u_sw.xfer(0, TCI_OFF_VALID_MAP, 0, q);
         chk(q, {16'h0, vm});
         u_sw.xfer(1, TCI_OFF_WAIT, 1, q);
         for (i = 0; i < 40 && wdone !== 1'b1; i++) @(posedge mclk_in);
         chk(wdone, 1);
         u_sw.xfer(0, TCI_OFF_STATUS, 0, q);
         chk(q[5:1], {4'h4, !ok});
         u_sw.xfer(1, TCI_OFF_STATUS, 32'h12, q);
         $display("test %0d done", r);
      end
      print_verdict;
   end
endmodule
